/* shta_top.sv */
// Overview of operation
// [RULE_01] Read drives addressed byte when output enabled.
// [RULE_02] Write spans later fall to earlier rise.
// [RULE_03] Host holds address stable during writes.
// [RULE_04] Write enable low turns data outputs off.
// [RULE_05] Power fail blocks all accesses.
// [RULE_06] Serial 64-bit key precedes clock access.
// [RULE_07] Next 64 cycles transfer clock bits.
// [RULE_08] A read arms the key pointer at zero.
// [RULE_09] Key writes still store to memory.
// [RULE_10] Match advances pointer; mismatch freezes recognition.
// [RULE_11] Read during recognition restarts the pointer.
// [RULE_12] Reads shift out, writes shift in.
// [RULE_13] Cycles without chip enable disturb nothing.
// [RULE_14] Eight registers, bit 0 of reg 0 first.
// [RULE_15] Host writes whole 8-bit groups.
// [RULE_16] Registers are kept in BCD.
// [RULE_17] Calendar counting with month and leap rollover.
// [RULE_18] Hours bit 7 selects 12-hour mode.
// [RULE_19] Hours bit 5 is PM or twenties.
// [RULE_20] Day bit 4 ignores reset pin.
// [RULE_21] Day bit 5 stops the oscillator.
// [RULE_22] Top address doubles as reset on variant.
// [RULE_23] Unused register bits read as zero.
// [RULE_24] Key value and layout are parameters.
// [RULE_25] After 64 transfers return to memory mode.
module shta_top #(
    parameter logic [63:0] KEY         = shta_pkg::KEY_DEFAULT,  // [RULE_24]
    parameter bit          RESET_PIN   = 1'b1,
    parameter int          TICK_CYCLES = shta_pkg::TICK_CYCLES
) (
    input  wire logic                         CLK_I,          // 10 MHz clock.
    input  wire logic                         RST_I,          // Synchronous reset, high.
    input  wire logic                         CE_N_I,         // Chip enable, low.
    input  wire logic                         OE_N_I,         // Output enable, low.
    input  wire logic                         WE_N_I,         // Write enable, low.
    input  wire logic [shta_pkg::ADDR_W-1:0]  ADDR_I,         // address_inputs; top bit may be reset.
    input  wire logic [shta_pkg::DATA_W-1:0]  DQ_I,           // Data lines in.
    output logic      [shta_pkg::DATA_W-1:0]  DQ_O,           // Data lines out.
    output logic                              DQ_OE_O,        // Data output enable, high.
    input  wire logic                         POWER_FAIL_I    // power_fail_threshold crossed, high.
);
    // =====================================================================
    // Pin synchronisers: three stages, a change counts when 2 and 3 agree.
    // =====================================================================
    localparam int NS = 3 + shta_pkg::ADDR_W + shta_pkg::DATA_W + 1;
    logic [NS-1:0] s1;
    logic [NS-1:0] s2;
    logic [NS-1:0] s3;
    logic [NS-1:0] f;

    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            s1 <= {3'b111, {(NS-3){1'b0}}};
            s2 <= {3'b111, {(NS-3){1'b0}}};
            s3 <= {3'b111, {(NS-3){1'b0}}};
        end
        else
        begin
            s1 <= {CE_N_I, OE_N_I, WE_N_I, ADDR_I, DQ_I, POWER_FAIL_I};
            s2 <= s1;
            s3 <= s2;
        end
    end

    genvar g;
    for (g = 0; g < NS; g++)
    begin : g_filt
        always_ff @(posedge CLK_I)
        begin
            if (RST_I)
            begin
                f[g] <= (g >= NS - 3);
            end
            else if (s2[g] == s3[g])
            begin
                f[g] <= s3[g];
            end
        end
    end

    logic                        ce_n;
    logic                        oe_n;
    logic                        we_n;
    logic [shta_pkg::ADDR_W-1:0] addr;
    logic [shta_pkg::DATA_W-1:0] din;
    logic                        pfail;
    assign {ce_n, oe_n, we_n, addr, din, pfail} = f;

    // =====================================================================
    // Cycle detection.
    // =====================================================================
    logic wr_act;
    logic rd_act;
    logic wr_prev;
    logic rd_prev;
    logic wr_end;
    logic rd_start;
    logic rd_end;
    logic reset_pin_abort;
    logic [shta_pkg::ADDR_W-1:0] mem_addr;
    logic [shta_pkg::DATA_W-1:0] wr_data;
    logic [shta_pkg::DATA_W-1:0] mem_rdata;
    logic [63:0]                 regs;

    // Write spans from the later falling edge to the earlier rising edge.
    assign wr_act   = !ce_n && !we_n && !pfail;                               // [RULE_02] [RULE_05]
    assign rd_act   = !ce_n && we_n && !pfail;                                // [RULE_01] [RULE_05] [RULE_13]
    assign wr_end   = wr_prev && !wr_act && !pfail;
    assign rd_start = rd_act && !rd_prev;
    // A transfer read moves the image at its end, so the bit stands for the whole read.
    assign rd_end   = rd_prev && !rd_act && !pfail;

    // On the surface-mount build the top address is an active-low reset. [RULE_22]
    assign reset_pin_abort = RESET_PIN && !addr[shta_pkg::ADDR_W-1] &&
                             !regs[shta_pkg::REG_DAY*8 + shta_pkg::DAY_RST_IGN]; // [RULE_20]
    assign mem_addr = RESET_PIN ? {1'b0, addr[shta_pkg::ADDR_W-2:0]} : addr;

    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            wr_prev <= 1'b0;
            rd_prev <= 1'b0;
            wr_data <= '0;
        end
        else
        begin
            wr_prev <= wr_act;
            rd_prev <= rd_act;
            if (wr_act)
            begin
                // Data is latched while the write is active; the host keeps the address steady. [RULE_03]
                wr_data <= din;
            end
        end
    end

    // =====================================================================
    // Key recognition and transfer sequencing.
    // =====================================================================
    shta_pkg::shta_mode_t mode;
    logic [shta_pkg::PTR_W-1:0] ptr;
    logic [63:0]                shift;
    logic                       load;

    always_ff @(posedge CLK_I)
    begin
        load <= 1'b0;
        if (RST_I)
        begin
            mode  <= shta_pkg::ST_IDLE;
            ptr   <= shta_pkg::PTR_ZERO;
            shift <= '0;
        end
        else if (reset_pin_abort && mode == shta_pkg::ST_XFER)
        begin
            // Abort leaves the clock registers untouched. [RULE_20]
            mode <= shta_pkg::ST_IDLE;
            ptr  <= shta_pkg::PTR_ZERO;
        end
        else
        begin
            case (mode)
                shta_pkg::ST_IDLE, shta_pkg::ST_MATCH:
                begin
                    if (rd_start)
                    begin
                        mode <= shta_pkg::ST_MATCH;                           // [RULE_08] [RULE_11]
                        ptr  <= shta_pkg::PTR_ZERO;
                    end
                    else if (wr_end && mode == shta_pkg::ST_MATCH)
                    begin
                        if (wr_data[0] == KEY[ptr[5:0]])                      // [RULE_06] [RULE_10]
                        begin
                            if (ptr == shta_pkg::PTR_LAST)
                            begin
                                mode  <= shta_pkg::ST_XFER;                   // [RULE_07]
                                ptr   <= shta_pkg::PTR_ZERO;
                                shift <= regs;                                // [RULE_14]
                            end
                            else
                            begin
                                ptr <= ptr + shta_pkg::PTR_ONE;
                            end
                        end
                        else
                        begin
                            mode <= shta_pkg::ST_IDLE;                        // [RULE_10]
                        end
                    end
                end
                shta_pkg::ST_XFER:
                begin
                    if (rd_end || wr_end)
                    begin
                        // Bit 0 of register 0 moves first. [RULE_12] [RULE_14]
                        shift <= {(wr_end ? wr_data[0] : shift[0]), shift[63:1]};
                        if (ptr == shta_pkg::PTR_LAST)
                        begin
                            mode <= shta_pkg::ST_IDLE;                        // [RULE_25]
                            ptr  <= shta_pkg::PTR_ZERO;
                            load <= 1'b1;
                        end
                        else
                        begin
                            ptr <= ptr + shta_pkg::PTR_ONE;
                        end
                    end
                end
                default:
                begin
                    mode <= shta_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Full 64-bit write-back; a reading pass rotates the image back intact. [RULE_15]
    logic [63:0] load_val;
    assign load_val = {(wr_end ? wr_data[0] : shift[0]), shift[63:1]};
    logic        load_q;
    logic [63:0] load_img;

    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            load_q   <= 1'b0;
            load_img <= '0;
        end
        else
        begin
            load_q <= (mode == shta_pkg::ST_XFER) && (rd_end || wr_end) &&
                      (ptr == shta_pkg::PTR_LAST) && !reset_pin_abort;
            load_img <= load_val;
        end
    end

    shta_clock #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_clock (
        .clk_i      (CLK_I),
        .rst_i      (RST_I),
        .load_i     (load_q),
        .load_val_i (load_img),
        .regs_o     (regs)
    );

    // =====================================================================
    // Memory array: key writes still land in RAM; transfer cycles do not.
    // =====================================================================
    logic mem_we;
    assign mem_we = wr_act && !wr_prev && (mode != shta_pkg::ST_XFER);     // [RULE_07] [RULE_09]

    shta_sram u_sram (
        .clk_i   (CLK_I),
        .we_i    (mem_we),
        .addr_i  (mem_addr),
        .wdata_i (din),
        .rdata_o (mem_rdata)
    );

    // =====================================================================
    // Output drive.
    // =====================================================================
    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            DQ_O <= '0;
        end
        else if (mode == shta_pkg::ST_XFER)
        begin
            DQ_O <= {7'h00, shift[0]};                                        // [RULE_12]
        end
        else
        begin
            DQ_O <= mem_rdata;                                                // [RULE_01]
        end
    end

    // Write enable forces the outputs off even with output enable low.
    assign DQ_OE_O = rd_act && !oe_n;                                         // [RULE_04]
    logic unused_load;
    assign unused_load = load;
endmodule

/* shta_pkg.sv */
package shta_pkg;
    // =====================================================================
    // Array and key geometry.
    // =====================================================================
    localparam int ADDR_W    = 15;
    localparam int DATA_W    = 8;
    localparam int KEY_BITS  = 64;
    localparam int PTR_W     = 7;
    localparam int NUM_REGS  = 8;
    localparam logic [PTR_W-1:0] PTR_LAST = 7'h3f;
    localparam logic [PTR_W-1:0] PTR_ZERO = 7'h00;
    localparam logic [PTR_W-1:0] PTR_ONE  = 7'h01;
    // Arbitrary neutral key value; a real part supplies its own.
    localparam logic [KEY_BITS-1:0] KEY_DEFAULT = 64'h5ca3_3ac5_5ca3_3ac5;

    // =====================================================================
    // Timekeeper register indices and fields.
    // =====================================================================
    localparam int REG_HUND = 0;
    localparam int REG_SEC  = 1;
    localparam int REG_MIN  = 2;
    localparam int REG_HOUR = 3;
    localparam int REG_DAY  = 4;
    localparam int REG_DATE = 5;
    localparam int REG_MON  = 6;
    localparam int REG_YEAR = 7;
    localparam int HOUR_MODE_BIT  = 7;
    localparam int HOUR_PM_BIT    = 5;
    localparam int DAY_RST_IGN    = 4;
    localparam int DAY_OSC_STOP   = 5;
    // Bits that exist in each register; the rest read as zero.
    localparam logic [63:0] REG_MASKS = {8'hff, 8'h1f, 8'h3f, 8'h37, 8'hbf, 8'h7f, 8'h7f, 8'hff};
    localparam logic [63:0] REG_RESET = {8'h00, 8'h01, 8'h01, 8'h30, 8'h00, 8'h00, 8'h00, 8'h00};

    // =====================================================================
    // Timing.
    // =====================================================================
    localparam int CLK_HZ      = 10_000_000;
    localparam int TICK_HZ     = 100;
    localparam int TICK_CYCLES = CLK_HZ / TICK_HZ;

    typedef enum logic [1:0] {ST_IDLE, ST_MATCH, ST_XFER} shta_mode_t;
endpackage

/* shta_sram.sv */
module shta_sram #(
    parameter int AW = shta_pkg::ADDR_W,
    parameter int DW = shta_pkg::DATA_W
) (
    input  wire logic          clk_i,    // System clock.
    input  wire logic          we_i,     // Write strobe, one cycle.
    input  wire logic [AW-1:0] addr_i,   // Byte address.
    input  wire logic [DW-1:0] wdata_i,  // Write data.
    output logic      [DW-1:0] rdata_o   // Registered read data.
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge clk_i)
    begin
        if (we_i)
        begin
            mem[addr_i] <= wdata_i;
        end
        rdata_o <= mem[addr_i];
    end
endmodule

/* shta_clock.sv */
module shta_clock #(
    parameter int TICK_CYCLES = shta_pkg::TICK_CYCLES
) (
    input  wire logic        clk_i,      // System clock.
    input  wire logic        rst_i,      // Synchronous reset.
    input  wire logic        load_i,     // Load all registers, one cycle.
    input  wire logic [63:0] load_val_i, // Registers 0..7, register 0 low.
    output logic      [63:0] regs_o      // Current registers.
);
    // =====================================================================
    // BCD helpers.
    // =====================================================================
    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        if (v[3:0] == 4'h9)
        begin
            return {v[7:4] + 4'h1, 4'h0};
        end
        return {v[7:4], v[3:0] + 4'h1};
    endfunction

    function automatic logic [7:0] days_in(input logic [7:0] mon, input logic [7:0] yr);
        logic [4:0] y;
        // Ten times the tens digit is twice it modulo four, so this sum keeps the year's residue.
        y = 5'(yr[7:4] * 2) + 5'(yr[3:0]);
        case (mon)
            8'h02:   return (y[1:0] == 2'h0) ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
            default: return 8'h31;
        endcase
    endfunction

    localparam int CW = $clog2(TICK_CYCLES);
    logic [CW-1:0] div;
    logic          tick;
    logic [7:0]    r [0:7];
    logic          run;
    logic          leap_ok;

    assign run = ~r[shta_pkg::REG_DAY][shta_pkg::DAY_OSC_STOP];                // [RULE_21]
    assign tick = run && (div == CW'(TICK_CYCLES - 1));
    assign leap_ok = 1'b1;

    always_ff @(posedge clk_i)
    begin
        if (rst_i || !run || tick)
        begin
            div <= '0;
        end
        else
        begin
            div <= div + CW'(1);
        end
    end

    genvar g;
    for (g = 0; g < 8; g++)
    begin : g_out
        assign regs_o[g*8 +: 8] = r[g] & shta_pkg::REG_MASKS[g*8 +: 8];      // [RULE_23]
    end

    // Carry chain in BCD; each field rolls only when all lower fields except the day of week roll.
    always_ff @(posedge clk_i)
    begin
        logic [7:0] h;
        logic [7:0] hr;
        logic       c;
        h  = '0;
        hr = r[shta_pkg::REG_HOUR];
        c  = 1'b0;
        if (rst_i)
        begin
            for (int i = 0; i < 8; i++)
            begin
                r[i] <= shta_pkg::REG_RESET[i*8 +: 8];
            end
        end
        else if (load_i)
        begin
            for (int i = 0; i < 8; i++)
            begin
                r[i] <= load_val_i[i*8 +: 8] & shta_pkg::REG_MASKS[i*8 +: 8];  // [RULE_23]
            end
        end
        else if (tick)                                                        // [RULE_16] [RULE_17]
        begin
            c = (r[0] == 8'h99);
            r[0] <= c ? 8'h00 : bcd_inc(r[0]);
            if (c)
            begin
                c = (r[1] == 8'h59);
                r[1] <= c ? 8'h00 : bcd_inc(r[1]);
            end
            if (c)
            begin
                c = (r[2] == 8'h59);
                r[2] <= c ? 8'h00 : bcd_inc(r[2]);
            end
            if (c)
            begin
                if (hr[shta_pkg::HOUR_MODE_BIT])                             // [RULE_18]
                begin
                    // 12-hour: 12 -> 01, 11 -> 12 toggles afternoon_flag.  [RULE_19]
                    h = {3'b000, hr[4:0]};
                    c = (h == 8'h11) && hr[shta_pkg::HOUR_PM_BIT];
                    if (h == 8'h12)
                    begin
                        h = 8'h01;
                    end
                    else
                    begin
                        h = bcd_inc(h);
                    end
                    r[3] <= {hr[7], 1'b0, hr[5] ^ (h == 8'h12), h[4:0]};
                end
                else
                begin
                    c = (hr[5:0] == 6'h23);
                    h = c ? 8'h00 : bcd_inc({2'b00, hr[5:0]});
                    r[3] <= {hr[7], 1'b0, h[5:0]};
                end
            end
            if (c)
            begin
                r[4] <= {r[4][7:3], (r[4][2:0] == 3'h7) ? 3'h1 : r[4][2:0] + 3'h1};
                c = (r[5] == days_in(r[6], r[7])) && leap_ok;
                r[5] <= c ? 8'h01 : bcd_inc(r[5]);
            end
            if (c)
            begin
                c = (r[6] == 8'h12);
                r[6] <= c ? 8'h01 : bcd_inc(r[6]);
            end
            if (c)
            begin
                r[7] <= (r[7] == 8'h99) ? 8'h00 : bcd_inc(r[7]);
            end
        end
    end
endmodule

/* shta_top_sva.sv */
module shta_chk (
    input  wire logic                        CLK_I,        // Clock.
    input  wire logic                        RST_I,        // Reset.
    input  wire logic                        CE_N_I,       // Chip enable.
    input  wire logic                        OE_N_I,       // Output enable.
    input  wire logic                        WE_N_I,       // Write enable.
    input  wire logic [shta_pkg::ADDR_W-1:0] ADDR_I,       // Address.
    input  wire logic [shta_pkg::DATA_W-1:0] DQ_I,         // Data in.
    input  wire logic [shta_pkg::DATA_W-1:0] DQ_O,         // Data out.
    input  wire logic                        DQ_OE_O,      // Drive enable.
    input  wire logic                        POWER_FAIL_I  // Power fail.
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       rd_now;
    logic [3:0] rd_run;
    logic [3:0] ce_hi_run;
    logic [3:0] pf_run;
    logic [3:0] wr_run;
    logic [3:0] stab_run;
    logic [3:0] since_rd;
    assign rd_now = !CE_N_I && !OE_N_I && WE_N_I && !POWER_FAIL_I;
    // =====================================
    // Run counters, saturating at 15.
    // =====================================
    function automatic logic [3:0] bump(input logic hit, input logic [3:0] cnt);
        return hit ? cnt + 4'(cnt != 4'hf) : 4'h0;
    endfunction
    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            rd_run    <= 4'h0;
            ce_hi_run <= 4'h0;
            pf_run    <= 4'h0;
            wr_run    <= 4'h0;
            stab_run  <= 4'h0;
            since_rd  <= 4'hf;
        end
        else
        begin
            rd_run    <= bump(rd_now, rd_run);
            ce_hi_run <= bump(CE_N_I, ce_hi_run);
            pf_run    <= bump(POWER_FAIL_I, pf_run);
            wr_run    <= bump(!CE_N_I && !WE_N_I, wr_run);
            stab_run  <= bump(rd_now && $stable(ADDR_I), stab_run);
            since_rd  <= rd_now ? 4'h0 : bump(1'b1, since_rd);
        end
    end
    // =====================================
    // Properties.
    // =====================================
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (RST_I);
    AST_OE_ON: assert property (rd_run >= 4'h8 |-> DQ_OE_O)
        else $error("data not driven during a held read");
    AST_OE_CAUSE: assert property (DQ_OE_O |-> since_rd <= 4'h8)
        else $error("data driven with no recent read");
    AST_DQ_HOLD: assert property (stab_run >= 4'ha |-> $stable(DQ_O))
        else $error("read data moved during a steady read");
    AST_WRITE_QUIET: assert property (wr_run >= 4'h8 |-> !DQ_OE_O)
        else $error("data driven during a write");
    AST_WE_TURNOFF: assert property ($fell(WE_N_I) && !CE_N_I && !OE_N_I |-> ##[1:8] !DQ_OE_O)
        else $error("outputs not released after write enable fell");
    AST_PF_BLOCK: assert property (pf_run >= 4'h8 |-> !DQ_OE_O)
        else $error("data driven during power fail");
    AST_CE_IDLE: assert property (ce_hi_run >= 4'h8 |-> !DQ_OE_O)
        else $error("data driven while deselected");
    AST_RESET_QUIET: assert property ($fell(RST_I) |-> DQ_O == 8'h00 && !DQ_OE_O)
        else $error("outputs not quiet after reset");
    cover property (rd_run == 4'h8);
    cover property ($fell(WE_N_I) && !CE_N_I && !OE_N_I);
    cover property (pf_run == 4'h8);
endmodule

bind shta_top shta_chk u_chk (
    .CLK_I(CLK_I), .RST_I(RST_I), .CE_N_I(CE_N_I), .OE_N_I(OE_N_I), .WE_N_I(WE_N_I),
    .ADDR_I(ADDR_I), .DQ_I(DQ_I), .DQ_O(DQ_O), .DQ_OE_O(DQ_OE_O), .POWER_FAIL_I(POWER_FAIL_I)
);

/* shta_host.sv */
module shta_host (
    input  wire logic        clk_i,   // Bench clock.
    input  wire logic [7:0]  dq_i,    // Device data out.
    output logic             ce_n_o,  // Chip enable.
    output logic             oe_n_o,  // Output enable.
    output logic             we_n_o,  // Write enable.
    output logic [14:0]      addr_o,  // Address; top bit kept high.
    output logic [7:0]       dq_o     // Data to device.
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [14:0] SCR = 15'h4010;
    initial
    begin
        ce_n_o = 1'b1;
        oe_n_o = 1'b1;
        we_n_o = 1'b1;
        addr_o = SCR;
        dq_o   = 8'h00;
    end
    // =====================================
    // Bus cycles.
    // =====================================
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    // Twelve cycles in the active phase and six idle, so the pin filter and the read path settle before sampling.
    task automatic cyc(input logic ce_n, oe_n, we_n, input logic [14:0] a, input logic [7:0] d, output logic [7:0] q);
        addr_o = a;
        dq_o   = d;
        ce_n_o = ce_n;
        oe_n_o = oe_n;
        we_n_o = we_n;
        step(12);
        q      = dq_i;
        ce_n_o = 1'b1;
        oe_n_o = 1'b1;
        we_n_o = 1'b1;
        dq_o   = ~d;
        step(6);
    endtask
    task automatic rd(input logic [14:0] a, output logic [7:0] q);
        cyc(1'b0, 1'b0, 1'b1, a, dq_o, q);
    endtask
    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        logic [7:0] q;
        cyc(1'b0, 1'b1, 1'b0, a, d, q);
    endtask
    // Optional noise adds deselected cycles with wrong data between key bits.
    task automatic unlock(input int nbits, input logic bad, input logic noise);
        logic [7:0] q;
        rd(SCR, q);
        for (int i = 0; i < nbits; i++)
        begin
            wr(SCR, {7'h55, shta_pkg::KEY_DEFAULT[i] ^ (bad && i == 0)});
            if (noise)
            begin
                cyc(1'b1, 1'b1, 1'b0, 15'h4777, {7'h00, ~shta_pkg::KEY_DEFAULT[i]}, q);
                cyc(1'b1, 1'b0, 1'b1, 15'h4777, 8'h00, q);
            end
        end
    endtask
    task automatic xfer_rd(output logic [63:0] v);
        logic [7:0] q;
        for (int i = 0; i < 64; i++)
        begin
            rd(SCR, q);
            v[i] = q[0];
        end
    endtask
    task automatic xfer_wr(input logic [63:0] v);
        for (int i = 0; i < 64; i++)
            wr(SCR, {7'h00, v[i]});
    endtask
endmodule

/* sram_hidden_timekeeper_access_bench.sv */
module sram_hidden_timekeeper_access_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        pf = 1'b0;
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic [14:0] addr;
    logic [7:0]  din;
    logic [7:0]  dout;
    logic        dout_en;
    logic [7:0]  q;
    logic [63:0] v;
    int          n_errors = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    localparam logic [63:0] WVAL = 64'h9912_c9f2_17d9_3042;
    localparam logic [63:0] START [2] = '{64'h0102_2813_b159_5999, 64'h0402_2813_2359_5999};
    localparam logic [47:0] AFTER [2] = '{48'h0103_0114_9200, 48'h0402_2914_0000};

    always #50 clk = ~clk;

    shta_top #(.TICK_CYCLES(10)) DUT (
        .CLK_I(clk), .RST_I(rst), .CE_N_I(ce_n), .OE_N_I(oe_n), .WE_N_I(we_n), .ADDR_I(addr),
        .DQ_I(din), .DQ_O(dout), .DQ_OE_O(dout_en), .POWER_FAIL_I(pf)
    );
    shta_host host (
        .clk_i(clk), .dq_i(dout), .ce_n_o(ce_n), .oe_n_o(oe_n), .we_n_o(we_n), .addr_o(addr), .dq_o(din)
    );

    // =====================================
    // Reporting.
    // =====================================
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d, errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            n_errors++;
            print_verdict();
        end
    end

    // =====================================
    // Scenarios.
    // =====================================
    initial
    begin
        repeat (16) @(posedge clk);
        #1;
        rst = 1'b0;
        host.step(4);
        host.unlock(64, 1'b0, 1'b0);
        host.xfer_rd(v);
        check(v, shta_pkg::REG_RESET);
        host.rd(15'h4010, q);
        check(64'(q), {56'h0, 7'h55, shta_pkg::KEY_DEFAULT[63]});
        host.cyc(1'b0, 1'b0, 1'b0, 15'h4123, 8'ha7, q);
        host.rd(15'h4123, q);
        check(64'(q), 64'ha7);
        host.wr(15'h4200, 8'h11);
        pf = 1'b1;
        host.step(4);
        host.wr(15'h4200, 8'hee);
        host.rd(15'h4200, q);
        pf = 1'b0;
        host.step(4);
        host.rd(15'h4200, q);
        check(64'(q), 64'h11);
        host.unlock(64, 1'b0, 1'b1);
        host.xfer_wr(WVAL);
        host.unlock(64, 1'b0, 1'b0);
        host.xfer_rd(v);
        check(v, WVAL & shta_pkg::REG_MASKS);
        host.unlock(64, 1'b1, 1'b0);
        host.wr(15'h4300, 8'h5a);
        host.rd(15'h4300, q);
        check(64'(q), 64'h5a);
        host.unlock(20, 1'b0, 1'b0);
        host.unlock(64, 1'b0, 1'b0);
        host.xfer_rd(v);
        check(v, WVAL & shta_pkg::REG_MASKS);
        // Seconds keep running while the read-back key goes in, so only minutes and up are compared.
        for (int i = 0; i < 2; i++)
        begin
            host.unlock(64, 1'b0, 1'b0);
            host.xfer_wr(START[i]);
            host.unlock(64, 1'b0, 1'b0);
            host.xfer_rd(v);
            check(64'(v[63:16]), 64'(AFTER[i]));
        end
        print_verdict();
    end
endmodule
